// ### testbench/mr_ctrl.sv
// Controller model: issues mode register writes, reads and set-point selects.
// Assumes the bank samples strobes on the rising edge; all changes land on falling edges.
module mr_ctrl (
   input wire logic clk_i,
   output logic wr_stb_o,
   output logic rd_stb_o,
   output logic [5:0] addr_o,
   output logic [7:0] op_o,
   output logic acc_sel_o,
   output logic opr_sel_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {wr_stb_o, rd_stb_o, acc_sel_o, opr_sel_o} = 4'h0;
      addr_o = 6'h00;
      op_o = 8'h00;
   end
   task automatic cmd(input logic wr, input logic [5:0] a, input logic [7:0] d);
      @(negedge clk_i);
      wr_stb_o = wr;
      rd_stb_o = ~wr;
      addr_o = a;
      op_o = d;
      @(negedge clk_i);
      {wr_stb_o, rd_stb_o} = 2'h0;
      // Released lines must not keep showing the last command
      addr_o = ~a;
      op_o = ~d;
   endtask : cmd
   task automatic sel(input logic acc, input logic opr);
      @(negedge clk_i);
      acc_sel_o = acc;
      opr_sel_o = opr;
   endtask : sel
endmodule : mr_ctrl

// ### testbench/test_dram_id_calib_odt_mode_regs.sv
// Bench for the mode-register bank: reads, writes, pin strap and set points.
// Assumes the package and the bank are compiled first.
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("[ERR] %s exp %h got %h", n, e, g); end end
module test_dram_id_calib_odt_mode_regs import mode_regs_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] GEOM = {WIDTH_X16, DENSITY_16GB, TYPE_SIXTEEN_PREFETCH};
   logic ref_clk = 1'b0;
   logic rst_b, wr_stb, rd_stb, acc_sel, opr_sel, pin_gnd, zq_cmd, rd_valid, cal_rst, cal_start;
   logic [5:0] addr;
   logic [7:0] op, rd_data, test_mode;
   logic [2:0] dq_term, ca_term, n;
   int bad_count = 0;
   int num_checks = 0;
   always #2 ref_clk = ~ref_clk;
   mr_ctrl u_mr_ctrl (.clk_i(ref_clk), .wr_stb_o(wr_stb), .rd_stb_o(rd_stb), .addr_o(addr), .op_o(op),
      .acc_sel_o(acc_sel), .opr_sel_o(opr_sel));
   mode_regs u_mode_regs (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .wr_stb_i(wr_stb), .rd_stb_i(rd_stb),
      .addr_i(addr), .op_i(op), .setpoint_access_select_i(acc_sel), .setpoint_operate_select_i(opr_sel),
      .calib_pin_grounded_i(pin_gnd), .zq_cal_cmd_i(zq_cmd), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
      .data_lane_termination_o(dq_term), .command_bus_termination_o(ca_term), .test_mode_o(test_mode),
      .calibration_default_reset_o(cal_rst), .calibration_start_o(cal_start));
   task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
      u_mr_ctrl.cmd(1'b0, a, 8'h00);
      `CHK("rd_valid", 1'b1, rd_valid)
      `CHK("rd_data", e, rd_data)
   endtask : rd_chk
   // Counts start pulses over a window longer than the pulse latency
   task automatic zq_pulses(output logic [2:0] cnt);
      cnt = 3'h0;
      repeat (3) @(negedge ref_clk);
      zq_cmd = 1'b1;
      @(negedge ref_clk);
      zq_cmd = 1'b0;
      repeat (4) begin
         cnt = cnt + {2'h0, cal_start};
         @(negedge ref_clk);
      end
   endtask : zq_pulses
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : summarize
   initial begin
      #4000;
      bad_count++;
      summarize();
   end
   initial begin
      rst_b = 1'b0;
      pin_gnd = 1'b1;
      zq_cmd = 1'b0;
      repeat (4) @(negedge ref_clk);
      rst_b = 1'b1;
      repeat (4) @(negedge ref_clk);
      rd_chk(ADDR_MAKER, 8'h5a);
      rd_chk(ADDR_REV_ONE, 8'h01);
      rd_chk(ADDR_REV_TWO, 8'h00);
      rd_chk(ADDR_GEOMETRY, GEOM);
      u_mr_ctrl.cmd(1'b1, ADDR_GEOMETRY, 8'hff);
      rd_chk(ADDR_GEOMETRY, GEOM);
      $display("ids done");
      u_mr_ctrl.cmd(1'b1, ADDR_TEST, 8'h5c);
      rd_chk(ADDR_TEST, READ_ZERO);
      `CHK("test_mode", 8'h5c, test_mode)
      u_mr_ctrl.cmd(1'b1, ADDR_TEST, TEST_DISABLED);
      u_mr_ctrl.cmd(1'b1, ADDR_CALIB, 8'h01);
      `CHK("cal_rst", 1'b1, cal_rst)
      zq_pulses(n);
      `CHK("start_gnd", 3'h0, n)
      pin_gnd = 1'b0;
      zq_pulses(n);
      `CHK("start_tied", 3'h1, n)
      $display("calibration done");
      u_mr_ctrl.sel(1'b0, 1'b0);
      u_mr_ctrl.cmd(1'b1, ADDR_TERM, 8'hab);
      rd_chk(ADDR_TERM, READ_ZERO);
      `CHK("dq_term", 3'h3, dq_term)
      `CHK("ca_term", 3'h2, ca_term)
      u_mr_ctrl.sel(1'b1, 1'b0);
      u_mr_ctrl.cmd(1'b1, ADDR_TERM, 8'h65);
      repeat (2) @(negedge ref_clk);
      `CHK("dq_term", 3'h3, dq_term)
      u_mr_ctrl.sel(1'b1, 1'b1);
      repeat (2) @(negedge ref_clk);
      `CHK("ca_term", 3'h6, ca_term)
      `CHK("dq_term", 3'h5, dq_term)
      $display("termination done");
      summarize();
   end
endmodule : test_dram_id_calib_odt_mode_regs

// ### verilog/mode_regs.sv
// Mode-register bank: identification, configuration, test, calibration and termination.
// Assumes the command decoder delivers one-cycle write/read strobes on ref_clk_i with
// address and op byte; the set-point selects come in from the set-point register.
//
// Operation
// - Maker code register at 05h, read-only
// - First revision code at 06h, read-only
// - Second revision code at 07h, read-only
// - Type field reports sixteen-word prefetch
// - Density field encodes die size
// - Width field reports I/O width
// - Test register write-only, zero disables
// - Bit zero write triggers calibration default reset
// - Grounded reference pin ignores calibration commands
// - Resistor-tied pin allows calibration and reset
// - Termination register write-only, bits 7,3 reserved
// - Data-lane termination in bits two to zero
// - Command-bus termination in bits six to four
// - Writes reach set-point chosen by access select
// - Applied termination from operate select copy
// - Inactive copy ignored, freely rewritable
// - Access select is set-point register bit six
// - Operate select is set-point register bit seven
// - Read data on lines seven to zero
module mode_regs
   import mode_regs_pkg::*;
#(
   parameter logic [7:0] MAKER_CODE = 8'h5a,   // Arbitrary value
   parameter logic [7:0] REV_ONE = 8'h01,      // Arbitrary value
   parameter logic [7:0] REV_TWO = 8'h00,      // Arbitrary value
   parameter logic [3:0] DENSITY_CODE = DENSITY_16GB,
   parameter logic [1:0] WIDTH_CODE = WIDTH_X16
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic wr_stb_i,
   input wire logic rd_stb_i,
   input wire logic [5:0] addr_i,
   input wire logic [7:0] op_i,
   input wire logic setpoint_access_select_i,
   input wire logic setpoint_operate_select_i,
   input wire logic calib_pin_grounded_i,
   input wire logic zq_cal_cmd_i,
   output logic [7:0] rd_data_o,
   output logic rd_valid_o,
   output logic [2:0] data_lane_termination_o,
   output logic [2:0] command_bus_termination_o,
   output logic [7:0] test_mode_o,
   output logic calibration_default_reset_o,
   output logic calibration_start_o
);
   logic rst_s1_r;
   logic rst_s2_r;
   logic rst_b;
   logic grounded_s1_r;
   logic grounded_s2_r;
   logic [7:0] test_r;
   logic [2:0] dq_term_r [2];
   logic [2:0] ca_term_r [2];
   logic access_sp;
   logic operate_sp;
   logic wr_test;
   logic wr_calib;
   logic wr_term;
   logic [7:0] geometry;
   logic [7:0] rd_mux;

   // Address match, used by the write decode; the read select compares addr_i directly
   function automatic logic addr_is(
      input logic [5:0] a,
      input logic [5:0] target
   );
      return a == target;
   endfunction : addr_is

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end
   assign rst_b = rst_s2_r;

   // Pin strap, synchronised before use; resets to grounded so that no
   // calibration command slips through before the strap is known
   always_ff @(posedge ref_clk_i or negedge rst_b) begin
      if (!rst_b) begin
         grounded_s1_r <= 1'b1;
         grounded_s2_r <= 1'b1;
      end else begin
         grounded_s1_r <= calib_pin_grounded_i;
         grounded_s2_r <= grounded_s1_r;
      end
   end

   assign access_sp = setpoint_access_select_i;
   assign operate_sp = setpoint_operate_select_i;
   // Writes to 05h..08h decode to nothing, so the constants stay put
   assign wr_test = wr_stb_i && addr_is(addr_i, ADDR_TEST);
   assign wr_calib = wr_stb_i && addr_is(addr_i, ADDR_CALIB);
   assign wr_term = wr_stb_i && addr_is(addr_i, ADDR_TERM);
   assign geometry = {WIDTH_CODE, DENSITY_CODE, TYPE_SIXTEEN_PREFETCH};

   // Write-only registers read as zero
   assign rd_mux = (addr_i == ADDR_MAKER) ? MAKER_CODE :
                   (addr_i == ADDR_REV_ONE) ? REV_ONE :
                   (addr_i == ADDR_REV_TWO) ? REV_TWO :
                   (addr_i == ADDR_GEOMETRY) ? geometry : READ_ZERO;

   always_ff @(posedge ref_clk_i or negedge rst_b) begin
      if (!rst_b) begin
         test_r <= TEST_DISABLED;
      end else if (wr_test) begin
         test_r <= op_i;
      end
   end

   // Only the copy chosen by the access select is written; the other holds
   genvar sp;
   for (sp = 0; sp < 2; sp++) begin : g_setpoint
      always_ff @(posedge ref_clk_i or negedge rst_b) begin
         if (!rst_b) begin
            dq_term_r[sp] <= TERM_DISABLED;
            ca_term_r[sp] <= TERM_DISABLED;
         end else if (wr_term && (access_sp == 1'(sp))) begin
            dq_term_r[sp] <= op_i[DQ_TERM_LSB +: 3];
            ca_term_r[sp] <= op_i[CA_TERM_LSB +: 3];
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b) begin
      if (!rst_b) begin
         rd_data_o <= READ_ZERO;
         rd_valid_o <= 1'b0;
         data_lane_termination_o <= TERM_DISABLED;
         command_bus_termination_o <= TERM_DISABLED;
         test_mode_o <= TEST_DISABLED;
         calibration_default_reset_o <= 1'b0;
         calibration_start_o <= 1'b0;
      end else begin
         rd_data_o <= rd_stb_i ? rd_mux : READ_ZERO;
         rd_valid_o <= rd_stb_i;
         data_lane_termination_o <= dq_term_r[operate_sp];
         command_bus_termination_o <= ca_term_r[operate_sp];
         test_mode_o <= test_r;
         calibration_default_reset_o <= wr_calib && op_i[CAL_RESET_BIT];
         calibration_start_o <= zq_cal_cmd_i && !grounded_s2_r;
      end
   end

   // Read side: identification values, field codes and zero for everything else

   a_read_ident: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
      rd_stb_i && addr_i == ADDR_MAKER |=> rd_valid_o && rd_data_o == MAKER_CODE)
      else $error("maker code read wrong");

   a_read_rev_one: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
      rd_stb_i && addr_i == ADDR_REV_ONE |=> rd_data_o == REV_ONE)
      else $error("first revision read wrong");

   a_read_rev: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
      rd_stb_i && addr_i == ADDR_REV_TWO |=> rd_data_o == REV_TWO)
      else $error("revision read wrong");

   a_read_geom: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
      rd_stb_i && addr_i == ADDR_GEOMETRY |=> rd_data_o[1:0] == TYPE_SIXTEEN_PREFETCH)
      else $error("type field wrong");

   a_read_density: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
      rd_stb_i && addr_i == ADDR_GEOMETRY |=> rd_data_o[DENSITY_LSB +: 4] == DENSITY_CODE)
      else $error("density field wrong");

   // A reserved density code would mislead the controller about array size
   a_density_legal: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
      rd_stb_i && addr_i == ADDR_GEOMETRY |=> rd_data_o[5:2] <= 4'h6 || rd_data_o[5:2] == 4'hc)
      else $error("density code reserved");

   a_read_width: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
      rd_stb_i && addr_i == ADDR_GEOMETRY |=> rd_data_o[WIDTH_LSB +: 2] == WIDTH_CODE)
      else $error("width field wrong");

   a_width_legal: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
      rd_stb_i && addr_i == ADDR_GEOMETRY |=> rd_data_o[7] == 1'b0)
      else $error("width code reserved");

   a_ident_kept: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
      wr_stb_i && addr_i == ADDR_GEOMETRY ##1 rd_stb_i && addr_i == ADDR_GEOMETRY
      |=> rd_data_o == {WIDTH_CODE, DENSITY_CODE, TYPE_SIXTEEN_PREFETCH})
      else $error("read-only register changed");

   a_read_wo_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
      rd_stb_i && addr_i >= ADDR_TEST |=> rd_data_o == READ_ZERO)
      else $error("write-only read not zero");

   a_read_test_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
      rd_stb_i && addr_i == ADDR_TEST |=> rd_valid_o && rd_data_o == READ_ZERO)
      else $error("test register readable");

   a_read_cal_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
      rd_stb_i && addr_i == ADDR_CALIB |=> rd_valid_o && rd_data_o == READ_ZERO)
      else $error("calibration register readable");

   a_read_term_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
      rd_stb_i && addr_i == ADDR_TERM |=> rd_valid_o && rd_data_o == READ_ZERO)
      else $error("termination register readable");

   a_read_valid: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
      rd_stb_i |=> rd_valid_o)
      else $error("read valid missing");

   // Idle read lines sit at zero so stale bytes never reach the data lines
   a_read_idle: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
      !rd_stb_i |=> !rd_valid_o && rd_data_o == READ_ZERO)
      else $error("read data not zero when idle");

   // Test register

   a_test_write: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
      wr_stb_i && addr_i == ADDR_TEST |=> ##1 test_mode_o == $past(op_i, 2))
      else $error("test register not written");

   a_test_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
      !(wr_stb_i && addr_i == ADDR_TEST) |=> ##1 $stable(test_mode_o))
      else $error("test register changed unasked");

   // Calibration

   a_cal_reset: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
      wr_stb_i && addr_i == ADDR_CALIB && op_i[0] |=> calibration_default_reset_o)
      else $error("calibration reset missed");

   a_cal_quiet: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
      !(wr_stb_i && addr_i == ADDR_CALIB && op_i[CAL_RESET_BIT]) |=> !calibration_default_reset_o)
      else $error("spurious calibration reset");

   // The default reset stays available with a grounded pin, the only path left there
   a_cal_reset_gnd: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
      wr_calib && op_i[CAL_RESET_BIT] && grounded_s2_r |=> calibration_default_reset_o)
      else $error("default reset blocked by strap");

   a_cal_ignored: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
      grounded_s2_r |=> !calibration_start_o)
      else $error("calibration not ignored");

   a_cal_start: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
      zq_cal_cmd_i && !grounded_s2_r |=> calibration_start_o)
      else $error("calibration command lost");

   a_cal_no_cmd: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
      !zq_cal_cmd_i |=> !calibration_start_o)
      else $error("calibration start without command");

   // Termination set points

   sequence s_term_same;
      wr_stb_i && addr_i == ADDR_TERM && access_sp == operate_sp;
   endsequence

   sequence s_term_other;
      wr_stb_i && addr_i == ADDR_TERM && access_sp != operate_sp;
   endsequence

   sequence s_quiet_step;
      !wr_stb_i && $stable(operate_sp);
   endsequence

   a_ca_apply: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
      s_term_same ##1 s_quiet_step |=> command_bus_termination_o == $past(op_i[CA_TERM_LSB +: 3], 2))
      else $error("command-bus termination not applied");

   a_dq_inactive: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
      s_term_other ##1 s_quiet_step |=> $stable(data_lane_termination_o))
      else $error("inactive data-lane copy applied");

   a_term_steady: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
      !wr_stb_i ##1 $stable(operate_sp)
      |=> $stable(data_lane_termination_o) && $stable(command_bus_termination_o))
      else $error("termination moved without cause");

   sequence s_term_write;
      wr_stb_i && addr_i == ADDR_TERM && access_sp == operate_sp && op_i[2:0] != TERM_RESERVED;
   endsequence
   a_term_apply: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
      s_term_write ##1 !wr_stb_i && $stable(operate_sp) |=> data_lane_termination_o == $past(op_i[2:0], 2))
      else $error("termination not applied");
   a_term_inactive: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
      wr_stb_i && addr_i == ADDR_TERM && access_sp != operate_sp && $stable(operate_sp)
      |=> ##1 $stable(command_bus_termination_o) || $changed(operate_sp) || $past(!$stable(operate_sp)))
      else $error("inactive copy disturbed operation");
endmodule : mode_regs

// ### verilog/mode_regs_pkg.sv
// Constants for the identification, calibration and termination mode-register bank.
// Assumes mode addresses arrive as six-bit values from the command decoder.
package mode_regs_pkg;
   localparam logic [5:0] ADDR_MAKER = 6'h05;
   localparam logic [5:0] ADDR_REV_ONE = 6'h06;
   localparam logic [5:0] ADDR_REV_TWO = 6'h07;
   localparam logic [5:0] ADDR_GEOMETRY = 6'h08;
   localparam logic [5:0] ADDR_TEST = 6'h09;
   localparam logic [5:0] ADDR_CALIB = 6'h0a;
   localparam logic [5:0] ADDR_TERM = 6'h0b;
   localparam logic [5:0] ADDR_SETPOINT = 6'h0d;
   // Field positions
   localparam int TYPE_LSB = 0;
   localparam int DENSITY_LSB = 2;
   localparam int WIDTH_LSB = 6;
   localparam int CAL_RESET_BIT = 0;
   localparam int DQ_TERM_LSB = 0;
   localparam int CA_TERM_LSB = 4;
   localparam int SP_ACCESS_BIT = 6;
   localparam int SP_OPERATE_BIT = 7;
   // Codes and reset values
   localparam logic [1:0] TYPE_SIXTEEN_PREFETCH = 2'h0;
   localparam logic [3:0] DENSITY_16GB = 4'h4;
   localparam logic [1:0] WIDTH_X16 = 2'h0;
   localparam logic [2:0] TERM_DISABLED = 3'h0;
   localparam logic [2:0] TERM_RESERVED = 3'h7;
   localparam logic [7:0] TEST_DISABLED = 8'h00;
   localparam logic [7:0] READ_ZERO = 8'h00;
endpackage : mode_regs_pkg
